// file: src/gpio_port_defs.svh
// Register indexes, reset values and widths of the general purpose I/O port
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

`define GP_ADDR_W          4
`define GP_DATA_W          16

`define GP_OFF_DIRECTION   4'h0
`define GP_OFF_PIN_LEVEL   4'h1
`define GP_OFF_LATCH       4'h2
`define GP_OFF_OPEN_DRAIN  4'h3
`define GP_OFF_CHANGE_EN   4'h4
`define GP_OFF_PULLUP      4'h5
`define GP_OFF_PULLDOWN    4'h6
`define GP_OFF_ANALOG      4'h7
`define GP_OFF_IRQ_STATUS  4'h8
`define GP_OFF_IRQ_MASK    4'h9

`define GP_RST_DIRECTION   16'hFFFF
`define GP_RST_ANALOG      16'hFFFF
`define GP_RST_ZERO        16'h0000

`endif

// file: src/gpio_port_pkg.sv
// Carrier types of the general purpose I/O port
package gpio_port_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic [15:0] dir;
    logic [15:0] lat;
    logic [15:0] od;
    logic [15:0] ana;
  } pin_cfg_type;

endpackage : gpio_port_pkg

// file: src/gpio_port.sv
// Sixteen pin general purpose I/O port with change notification interrupt
`include "gpio_port_defs.svh"

module gpio_port #(
  parameter logic [15:0] PIN_IMPL_MASK    = 16'hFFFF,
  parameter logic [15:0] ANALOG_IMPL_MASK = 16'hFFFF
) (
  // Clock, reset, enable
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  // Register port
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  // Pins
  input  wire logic [15:0] PIN_IN,
  output logic      [15:0] PIN_OUT,
  output logic      [15:0] PIN_OE,
  output logic      [15:0] PULLUP_EN,
  output logic      [15:0] PULLDOWN_EN,
  output logic      [15:0] ANALOG_SEL,
  // Interrupt
  output logic             CHANGE_IRQ
);

  gpio_port_pkg::reg_req_type req;
  gpio_port_pkg::pin_cfg_type cfg_ff;
  gpio_port_pkg::pin_cfg_type nxt_cfg;

  logic [15:0] cn_en_ff;
  logic [15:0] nxt_cn_en;
  logic [15:0] pu_ff;
  logic [15:0] nxt_pu;
  logic [15:0] pd_ff;
  logic [15:0] nxt_pd;
  logic [15:0] status_ff;
  logic [15:0] nxt_status;
  logic [15:0] mask_ff;
  logic [15:0] nxt_mask;
  logic [15:0] sync_a_ff;
  logic [15:0] sync_b_ff;
  logic [15:0] prev_ff;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;

  logic [15:0] wdata_pin;
  logic [15:0] wdata_ana;
  logic [15:0] analog_in;
  logic [15:0] level_view;
  logic [15:0] change_vec;
  logic [15:0] clear_vec;
  logic [15:0] rd_view [0:15];

  // Write strobe for one register index, qualified by the clock enable
  function automatic logic wr_hit(input gpio_port_pkg::reg_req_type r, input logic [3:0] off, input logic en);
    wr_hit = en & r.wr & (r.addr == off);
  endfunction : wr_hit

  assign req.wr    = REG_WR;
  assign req.rd    = REG_RD;
  assign req.addr  = REG_ADDR;
  assign req.wdata = REG_WDATA;

  // Writes to absent bits are dropped here, so they also read back zero
  assign wdata_pin = req.wdata & PIN_IMPL_MASK;
  assign wdata_ana = req.wdata & PIN_IMPL_MASK & ANALOG_IMPL_MASK;

  // Next values of the configuration registers
  assign nxt_cfg.dir = wr_hit(req, `GP_OFF_DIRECTION, CE) ? (wdata_pin | ~PIN_IMPL_MASK) : cfg_ff.dir;
  // A write to the pin level register lands in the latch
  assign nxt_cfg.lat = (wr_hit(req, `GP_OFF_LATCH, CE) | wr_hit(req, `GP_OFF_PIN_LEVEL, CE)) ?
                       wdata_pin : cfg_ff.lat;
  assign nxt_cfg.od  = wr_hit(req, `GP_OFF_OPEN_DRAIN, CE) ? wdata_pin : cfg_ff.od;
  assign nxt_cfg.ana = wr_hit(req, `GP_OFF_ANALOG, CE) ? wdata_ana : cfg_ff.ana;
  assign nxt_cn_en   = wr_hit(req, `GP_OFF_CHANGE_EN, CE) ? wdata_pin : cn_en_ff;
  assign nxt_pu      = wr_hit(req, `GP_OFF_PULLUP, CE) ? wdata_pin : pu_ff;
  assign nxt_pd      = wr_hit(req, `GP_OFF_PULLDOWN, CE) ? wdata_pin : pd_ff;
  assign nxt_mask    = wr_hit(req, `GP_OFF_IRQ_MASK, CE) ? wdata_pin : mask_ff;

  // Change detection on the synchronised level; a fresh change beats a clear
  assign change_vec = (sync_b_ff ^ prev_ff) & cn_en_ff & PIN_IMPL_MASK;
  assign clear_vec  = wr_hit(req, `GP_OFF_IRQ_STATUS, CE) ? wdata_pin : `GP_RST_ZERO;
  assign nxt_status = (status_ff & ~clear_vec) | change_vec;

  // Read view: analog inputs read low regardless of the pin voltage
  assign analog_in  = cfg_ff.ana & cfg_ff.dir;
  assign level_view = sync_b_ff & ~analog_in & PIN_IMPL_MASK;

  assign rd_view[`GP_OFF_DIRECTION]  = cfg_ff.dir & PIN_IMPL_MASK;
  assign rd_view[`GP_OFF_PIN_LEVEL]  = level_view;
  assign rd_view[`GP_OFF_LATCH]      = cfg_ff.lat;
  assign rd_view[`GP_OFF_OPEN_DRAIN] = cfg_ff.od;
  assign rd_view[`GP_OFF_CHANGE_EN]  = cn_en_ff;
  assign rd_view[`GP_OFF_PULLUP]     = pu_ff;
  assign rd_view[`GP_OFF_PULLDOWN]   = pd_ff;
  assign rd_view[`GP_OFF_ANALOG]     = cfg_ff.ana;
  assign rd_view[`GP_OFF_IRQ_STATUS] = status_ff;
  assign rd_view[`GP_OFF_IRQ_MASK]   = mask_ff;

  // Unmapped indexes answer zero
  generate
    for (genvar gi = 10; gi < 16; gi++) begin : g_unmapped
      assign rd_view[gi] = `GP_RST_ZERO;
    end
  endgenerate

  assign nxt_rdata = (CE & req.rd) ? rd_view[req.addr] : rdata_ff;

  // Pin drivers: open drain keeps the enable only for a low latch
  assign PIN_OUT     = cfg_ff.lat & ~cfg_ff.od;
  // Analog selection does not block the digital driver
  assign PIN_OE      = ~cfg_ff.dir & (~cfg_ff.od | ~cfg_ff.lat) & PIN_IMPL_MASK;
  assign PULLUP_EN   = pu_ff;
  assign PULLDOWN_EN = pd_ff;
  assign ANALOG_SEL  = cfg_ff.ana;
  assign CHANGE_IRQ  = |(status_ff & mask_ff);
  assign REG_RDATA   = rdata_ff;

  // Two-stage synchroniser; only the second stage feeds logic
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync_a_ff <= `GP_RST_ZERO;
      sync_b_ff <= `GP_RST_ZERO;
    end else if (CE) begin
      sync_a_ff <= PIN_IN;
      sync_b_ff <= sync_a_ff;
    end
  end

  // Previous level is held while frozen, so a change made while
  // the clock was stopped is still flagged once it runs again
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prev_ff   <= `GP_RST_ZERO;
      status_ff <= `GP_RST_ZERO;
    end else if (CE) begin
      prev_ff   <= sync_b_ff;
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_ff.dir <= `GP_RST_DIRECTION;
      cfg_ff.lat <= `GP_RST_ZERO;
      cfg_ff.od  <= `GP_RST_ZERO;
      cfg_ff.ana <= `GP_RST_ANALOG & PIN_IMPL_MASK & ANALOG_IMPL_MASK;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cn_en_ff <= `GP_RST_ZERO;
      pu_ff    <= `GP_RST_ZERO;
      pd_ff    <= `GP_RST_ZERO;
      mask_ff  <= `GP_RST_ZERO;
      rdata_ff <= `GP_RST_ZERO;
    end else begin
      cn_en_ff <= nxt_cn_en;
      pu_ff    <= nxt_pu;
      pd_ff    <= nxt_pd;
      mask_ff  <= nxt_mask;
      rdata_ff <= nxt_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_rd_level;
    CE && REG_RD && (REG_ADDR == `GP_OFF_PIN_LEVEL);
  endsequence

  sequence s_rd_latch;
    CE && REG_RD && (REG_ADDR == `GP_OFF_LATCH);
  endsequence

  sequence s_enabled_change;
    CE && ((change_vec & mask_ff) != 16'h0000) && !wr_hit(req, `GP_OFF_IRQ_MASK, CE);
  endsequence

  property p_input_never_driven;
    (PIN_OE & cfg_ff.dir) == 16'h0000;
  endproperty
  a_input_never_driven: assert property (p_input_never_driven)
    else $error("pin driven while its direction is input");

  property p_level_read;
    s_rd_level |=> (REG_RDATA == ($past(sync_b_ff) & ~$past(analog_in) & PIN_IMPL_MASK));
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("pin level read does not match synchronised pins");

  property p_latch_read;
    s_rd_latch |=> (REG_RDATA == $past(cfg_ff.lat));
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("latch read does not return latch content");

  property p_open_drain_high_floats;
    (PIN_OE & cfg_ff.od & cfg_ff.lat) == 16'h0000 && (PIN_OUT & cfg_ff.od) == 16'h0000;
  endproperty
  a_open_drain_high_floats: assert property (p_open_drain_high_floats)
    else $error("open drain pin driven high");

  property p_push_pull_driven;
    ((~cfg_ff.dir & ~cfg_ff.od & PIN_IMPL_MASK) & ~PIN_OE) == 16'h0000 &&
    ((PIN_OUT ^ cfg_ff.lat) & ~cfg_ff.od) == 16'h0000;
  endproperty
  a_push_pull_driven: assert property (p_push_pull_driven)
    else $error("output pin not driving latch value");

  property p_change_raises_irq;
    s_enabled_change |=> CHANGE_IRQ;
  endproperty
  a_change_raises_irq: assert property (p_change_raises_irq)
    else $error("enabled unmasked change did not raise interrupt");

  property p_only_enabled_pins;
    CE |=> ((status_ff & ~$past(status_ff) & ~$past(cn_en_ff)) == 16'h0000);
  endproperty
  a_only_enabled_pins: assert property (p_only_enabled_pins)
    else $error("status set for a pin without change enable");

  property p_level_write_loads_latch;
    (CE && REG_WR && (REG_ADDR == `GP_OFF_PIN_LEVEL)) |=> (cfg_ff.lat == ($past(REG_WDATA) & PIN_IMPL_MASK));
  endproperty
  a_level_write_loads_latch: assert property (p_level_write_loads_latch)
    else $error("pin level write did not load latch");

  property p_absent_bits_zero;
    (REG_RDATA & ~PIN_IMPL_MASK) == 16'h0000;
  endproperty
  a_absent_bits_zero: assert property (p_absent_bits_zero)
    else $error("unimplemented bit read as one");

  property p_sync_two_stages;
    ARST_N && CE ##1 CE |=> (sync_b_ff == $past(PIN_IN, 2));
  endproperty
  a_sync_two_stages: assert property (p_sync_two_stages)
    else $error("pin level not delayed by two stages");

  property p_pulls_follow_regs;
    (CE && REG_WR && (REG_ADDR == `GP_OFF_PULLUP)) |=> (PULLUP_EN == ($past(REG_WDATA) & PIN_IMPL_MASK));
  endproperty
  a_pulls_follow_regs: assert property (p_pulls_follow_regs)
    else $error("pull-up enable does not follow write");

  sequence s_wr_status;
    CE && REG_WR && (REG_ADDR == `GP_OFF_IRQ_STATUS);
  endsequence

  sequence s_wr_direction;
    CE && REG_WR && (REG_ADDR == `GP_OFF_DIRECTION);
  endsequence

  sequence s_rd_unmapped;
    CE && REG_RD && (REG_ADDR > `GP_OFF_IRQ_MASK);
  endsequence

  // A clear only drops bits that saw no change in the same cycle
  property p_status_clear;
    s_wr_status |=> ((status_ff & $past(REG_WDATA) & ~$past(change_vec)) == 16'h0000);
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status bit survived its clearing write");

  property p_status_sticky;
    !(CE && REG_WR && (REG_ADDR == `GP_OFF_IRQ_STATUS)) |=> (($past(status_ff) & ~status_ff) == 16'h0000);
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("status bit dropped without a clearing write");

  property p_change_sets_status;
    (CE && (change_vec != 16'h0000)) |=> ((status_ff & $past(change_vec)) == $past(change_vec));
  endproperty
  a_change_sets_status: assert property (p_change_sets_status)
    else $error("detected change not recorded in status");

  property p_dir_write_lands;
    s_wr_direction |=> (cfg_ff.dir == ($past(REG_WDATA) | ~PIN_IMPL_MASK));
  endproperty
  a_dir_write_lands: assert property (p_dir_write_lands)
    else $error("direction write did not land");

  property p_unmapped_reads_zero;
    s_rd_unmapped |=> (REG_RDATA == 16'h0000);
  endproperty
  a_unmapped_reads_zero: assert property (p_unmapped_reads_zero)
    else $error("unmapped index read as nonzero");

  property p_analog_input_reads_low;
    s_rd_level |=> ((REG_RDATA & $past(analog_in)) == 16'h0000);
  endproperty
  a_analog_input_reads_low: assert property (p_analog_input_reads_low)
    else $error("analog input read as high");

  property p_open_drain_low_drives;
    ((~cfg_ff.dir & cfg_ff.od & ~cfg_ff.lat & PIN_IMPL_MASK) & ~PIN_OE) == 16'h0000;
  endproperty
  a_open_drain_low_drives: assert property (p_open_drain_low_drives)
    else $error("open drain pin not pulling low");

  property p_analog_output_drives;
    ((~cfg_ff.dir & cfg_ff.ana & ~cfg_ff.od & PIN_IMPL_MASK) & ~PIN_OE) == 16'h0000;
  endproperty
  a_analog_output_drives: assert property (p_analog_output_drives)
    else $error("analog selected output not driven");

  // Read data stand until the next accepted read
  property p_rdata_stands;
    !(CE && REG_RD) |=> $stable(REG_RDATA);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands)
    else $error("read data changed without a read");

  // Low clock enable stands for sleep: no state may move
  property p_frozen_asleep;
    !CE |=> ($stable(cfg_ff) && $stable(status_ff) && $stable(prev_ff) && $stable(sync_b_ff));
  endproperty
  a_frozen_asleep: assert property (p_frozen_asleep)
    else $error("state moved while clock enable low");

endmodule : gpio_port

// file: tb/pin_pad_model.sv
// Pad model: resolves each pin from port drive, external source and weak pulls
module pin_pad_model (
  // Clock for the floating-pin pattern
  input  wire logic        clk,
  // Port side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] pu_en,
  input  wire logic [15:0] pd_en,
  // External source
  input  wire logic [15:0] ext_val,
  input  wire logic [15:0] ext_en,
  output logic      [15:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] float_ff = 16'h0000;
  // Undriven pins wander so a stale level never reads back
  always @(posedge clk) float_ff <= ~pin_lvl;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i]) pin_lvl[i] = pin_out[i];
      else if (ext_en[i]) pin_lvl[i] = ext_val[i];
      else if (pu_en[i] | pd_en[i]) pin_lvl[i] = pu_en[i];
      else pin_lvl[i] = float_ff[i];
    end
  end
endmodule : pin_pad_model

// file: tb/tb_top.sv
// Self-checking bench for the general purpose I/O port
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk  = 1'b0;
  logic        arst_n    = 1'b0;
  logic        ce        = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] ext_val   = 16'h0000;
  logic [15:0] ext_en    = 16'hFFFF;
  wire  [15:0] rdata, pin_in, pin_out, pin_oe, pu_en, pd_en, ana_sel;
  wire         irq;
  int          num_errors  = 0;
  int          comparisons = 0;
  always #5 core_clk = ~core_clk;

  gpio_port dut (.CORE_CLK(core_clk), .ARST_N(arst_n), .CE(ce), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULLUP_EN(pu_en), .PULLDOWN_EN(pd_en),
    .ANALOG_SEL(ana_sel), .CHANGE_IRQ(irq));
  pin_pad_model pad (.clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pu_en(pu_en),
    .pd_en(pd_en), .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_in));

  task automatic chk16(string name, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask : chk16
  task automatic chk1(string name, logic exp, logic got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s exp %b got %b", name, exp, got);
    end
  endtask : chk1
  task automatic wr(logic [3:0] a, logic [15:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // Always at least one idle cycle after a write before the read strobe
  task automatic rd(logic [3:0] a, logic [15:0] exp, string name);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk16(name, exp, rdata);
  endtask : rd
  task automatic test_done();
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  function automatic logic [15:0] lvl_exp(logic [15:0] dr, lt, od, an, ev);
    logic [15:0] oe;
    oe = ~dr & (~od | ~lt);
    return ((oe & lt) | (~oe & ev)) & ~(an & dr);
  endfunction : lvl_exp

  initial begin
    logic [15:0] dr, lt, od, an, r, e;
    void'($urandom(32'h5ebcd020));
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], (i == 0 || i == 7) ? 16'hFFFF : 16'h0000, "reset");
    end
    wr(4'hC, 16'hFFFF);
    rd(4'hC, 16'h0000, "unmapped");
    for (int n = 0; n < 12; n++) begin
      dr = 16'($urandom);
      lt = 16'($urandom);
      od = (n == 0) ? 16'hFFFF : 16'($urandom);
      an = 16'($urandom);
      r  = 16'($urandom);
      e  = 16'($urandom);
      ext_val <= 16'($urandom);
      // Unsourced inputs settle to their weak pull
      ext_en  <= e | ~dr;
      wr(4'h0, dr);
      wr(n[0] ? 4'h1 : 4'h2, lt);
      wr(4'h3, od);
      wr(4'h5, r & dr);
      wr(4'h6, ~r & dr);
      wr(4'h7, an);
      rd(4'h2, lt, "latch");
      rd(4'h0, dr, "direction");
      chk16("oe", ~dr & (~od | ~lt), pin_oe);
      chk16("out", lt & ~od, pin_out);
      chk16("pullup", r & dr, pu_en);
      chk16("pulldown", ~r & dr, pd_en);
      chk16("analog", an, ana_sel);
      rd(4'h1, lvl_exp(dr, lt, od, an, (ext_val & ext_en) | (r & ~ext_en)), "pin level");
    end
    ext_en <= 16'hFFFF;
    wr(4'h0, 16'hFFFF);
    wr(4'h7, 16'h0000);
    wr(4'h9, 16'hFFFF);
    wr(4'h4, 16'h00F0);
    wr(4'h8, 16'hFFFF);
    rd(4'h8, 16'h0000, "status clear");
    @(posedge core_clk);
    ext_val <= ext_val ^ 16'h0F30;
    repeat (2) @(posedge core_clk);
    #1 chk1("irq early", 1'b0, irq);
    @(posedge core_clk);
    #1 chk1("irq", 1'b1, irq);
    rd(4'h8, 16'h0030, "status");
    wr(4'h9, 16'hFFCF);
    chk1("irq masked", 1'b0, irq);
    wr(4'h9, 16'hFFFF);
    wr(4'h8, 16'h0010);
    chk1("irq partial clear", 1'b1, irq);
    wr(4'h8, 16'h0020);
    chk1("irq cleared", 1'b0, irq);
    // Sleep: no clock enable, change is flagged once the port wakes
    @(posedge core_clk);
    ce      <= 1'b0;
    ext_val <= ext_val ^ 16'h0010;
    wr(4'h9, 16'h0000);
    rd(4'h0, 16'h0030, "read asleep");
    repeat (4) @(posedge core_clk);
    #1 chk1("irq asleep", 1'b0, irq);
    @(posedge core_clk);
    ce <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk1("irq wake", 1'b1, irq);
    rd(4'h9, 16'hFFFF, "mask kept");
    // Mid-run reset must restore direction and analog select
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    #1 chk1("irq after reset", 1'b0, irq);
    rd(4'h0, 16'hFFFF, "direction after reset");
    rd(4'h7, 16'hFFFF, "analog after reset");
    test_done();
  end
endmodule : tb_top
